//--- automatic_gain_scheduler_tb.sv
// Purpose: Self-checking bench of the gain scheduler
// Assumes: Short tick, so waits and ramps span a few hundred cycles
// Notes: Random status inputs from a fixed seed, corner cases by hand
module automatic_gain_scheduler_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import gain_sched_pkg::*;
    localparam int TICK = 45;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, watch = 1'b0;
    logic [4:0] addr = 5'h00;
    word_t wdata = 16'h0000;
    logic pos = 1'b0, done = 1'b0, near = 1'b0, pulse = 1'b0, fzero = 1'b0;
    logic gsel = 1'b0, refp = 1'b1, stopped = 1'b0, act, form;
    word_t rdata, spd, integ, posg, trq, frc, mfg, mfc, got, last;
    int mismatches = 0, samples_checked = 0, loop_errs, k, sel;
    word_t dflt [7] = '{16'h0190, 16'h07d0, 16'h0190, 16'h0064, 16'h0064, 16'h01f4, 16'h03e8};
    // ----------------------------------------
    // Design, loops and clock
    // ----------------------------------------
    gain_scheduler #(.TICK_CYCLES(TICK)) i_gain_scheduler (
        .CLK_SYS_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr), .WR_DATA_IN(wdata),
        .WR_STB_IN(wr), .RD_STB_IN(rd), .POS_CTRL_IN(pos), .POSITIONING_DONE_IN(done),
        .NEAR_IN(near), .REF_PULSE_IN(pulse), .FILTER_ZERO_IN(fzero), .GAIN_SEL_IN(gsel),
        .REF_PRESENT_IN(refp), .MOTOR_STOPPED_IN(stopped), .RD_DATA_OUT(rdata),
        .SPEED_GAIN_OUT(spd), .INTEGRAL_TIME_OUT(integ), .POSITION_GAIN_OUT(posg),
        .TORQUE_FILTER_OUT(trq), .FRICTION_GAIN_OUT(frc), .MF_GAIN_OUT(mfg),
        .MF_CORR_OUT(mfc), .ACTIVE_SET_OUT(act), .SPEED_FORM_OUT(form));
    gain_loop_model i_gain_loop_model (.clk_in(clk), .watch_in(watch), .speed_gain_in(spd),
        .integral_time_in(integ), .position_gain_in(posg), .range_errors_out(loop_errs));
    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end
    // ----------------------------------------
    // Bus, compare and expectation helpers
    // ----------------------------------------
    task automatic chk_word(input word_t exp, input word_t val);
        samples_checked++;
        if (val !== exp) begin
            mismatches++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, val);
        end
    endtask
    task automatic chk_bit(input logic exp, input logic val);
        chk_word({15'h0000, exp}, {15'h0000, val});
    endtask
    task automatic wr_reg(input logic [4:0] a, input word_t d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [4:0] a, output word_t d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic cond_a(input int s);
        case (s)
            0: return done;
            1: return !done;
            2: return near;
            3: return !near;
            4: return fzero && !pulse;
            default: return pulse;
        endcase
    endfunction
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h0785cf7b));
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        settle(4);
        watch = 1'b1;
        chk_word(16'h0190, posg);
        chk_word(16'h07d0, integ);
        chk_word(16'h0064, trq);
        chk_word(16'h0064, frc);
        for (int g = 0; g < 7; g++) begin
            for (int s = 0; s < 2; s++) begin
                rd_reg(5'h08 + 5'(2 * g + s), got);
                chk_word(dflt[g], got);
            end
        end
        rd_reg(5'h1f, got);
        chk_word(16'h0000, got);
        wr_reg(5'h0c, 16'h0000);
        rd_reg(5'h0c, got);
        chk_word(16'h000a, got);
        wr_reg(5'h10, 16'hffff);
        rd_reg(5'h10, got);
        chk_word(16'h03e8, got);
        chk_word(16'h03e8, frc);
        wr_reg(5'h14, 16'h0001);
        rd_reg(5'h14, got);
        chk_word(16'h01f4, got);
        wr_reg(5'h01, 16'hffff);
        rd_reg(5'h01, got);
        chk_word(16'hffff, got);
        wr_reg(5'h0c, 16'h0190);
        // Manual select, reserved mode behaves alike
        wr_reg(5'h09, 16'h0300);
        for (int m = 0; m < 2; m++) begin
            wr_reg(5'h00, 16'(1 - m));
            gsel <= 1'b1;
            settle(4);
            chk_bit(1'b1, act);
            chk_word(16'h0300, spd);
            @(posedge clk);
            gsel <= 1'b0;
            settle(4);
            chk_bit(1'b0, act);
            chk_word(16'h0190, spd);
        end
        // Model-follow set only moves when stopped and unreferenced
        wr_reg(5'h13, 16'h0258);
        gsel <= 1'b1;
        settle(4);
        chk_word(16'h01f4, mfg);
        chk_word(16'h01f4, mfc);
        @(posedge clk);
        refp <= 1'b0;
        stopped <= 1'b1;
        settle(4);
        chk_word(16'h0258, mfg);
        chk_word(16'h03e8, mfc);
        @(posedge clk);
        gsel <= 1'b0;
        refp <= 1'b1;
        // Random selector codes and status inputs in pattern 1
        for (int i = 0; i < 40; i++) begin
            sel = $urandom_range(5);
            k = $urandom_range(1);
            wr_reg(5'h00, 16'((k << 8) | (sel << 4) | 2));
            {pos, done, near, pulse, fzero} <= 5'($urandom);
            settle(3);
            chk_bit(pos ? cond_a(sel) : sel[0], act);
            chk_bit(k[0], form);
        end
        // Wait then linear ramp to set 2, then instant return
        wr_reg(5'h00, 16'h0002);
        wr_reg(5'h01, 16'h0000);
        wr_reg(5'h02, 16'h0000);
        wr_reg(5'h04, 16'h0000);
        wr_reg(5'h0d, 16'h03e8);
        {pos, done, near, pulse, fzero} <= 5'b10000;
        settle(3 * TICK);
        chk_word(16'h0190, posg);
        wr_reg(5'h01, 16'h0002);
        wr_reg(5'h03, 16'h0004);
        done <= 1'b1;
        settle(TICK);
        chk_word(16'h0190, posg);
        last = posg;
        k = 0;
        for (int c = 0; c < 7 * TICK && k < 4; c++) begin
            settle(1);
            if (posg !== last) begin
                k++;
                chk_word(16'(400 + 150 * k), posg);
                last = posg;
            end
        end
        chk_word(16'h03e8, posg);
        // Reverse in mid-ramp: wait holds the applied gain, then ramp back up
        wr_reg(5'h04, 16'h0004);
        done <= 1'b0;
        settle(2 * TICK + 10);
        @(posedge clk);
        done <= 1'b1;
        settle(2);
        last = posg;
        settle(TICK);
        chk_word(last, posg);
        settle(6 * TICK);
        chk_word(16'h03e8, posg);
        wr_reg(5'h04, 16'h0000);
        @(posedge clk);
        done <= 1'b0;
        for (int c = 0; c < 3 * TICK && posg !== 16'h0190; c++) begin
            settle(1);
        end
        chk_word(16'h0190, posg);
        chk_word(16'h0000, 16'(loop_errs));
        end_of_test();
    end
endmodule

//--- gain_loop_model.sv
// Purpose: Control loops that take the active gains
// Assumes: Gains are judged only while watch_in is high
// Notes: Counts cycles with a speed, integral or position word outside its settable range
module gain_loop_model
(
    input wire logic clk_in,
    input wire logic watch_in,
    input wire gain_sched_pkg::word_t speed_gain_in,
    input wire gain_sched_pkg::word_t integral_time_in,
    input wire gain_sched_pkg::word_t position_gain_in,
    output int range_errors_out = 0
);
    timeunit 1ns;
    timeprecision 100ps;
    import gain_sched_pkg::*;
    // ----------------------------------------
    // Range watch
    // ----------------------------------------
    // Words out of range would upset the loops
    always @(posedge clk_in) begin
        if (watch_in && (speed_gain_in < 16'h000a || speed_gain_in > 16'h4e20
            || position_gain_in < 16'h000a || position_gain_in > 16'h4e20
            || integral_time_in < 16'h000f || integral_time_in > 16'hc800)) begin
            range_errors_out <= range_errors_out + 1;
        end
    end
endmodule

//--- gain_ramp.sv
// Purpose: Linear move of one gain from the applied value to a set value
// Assumes: Steps arrive at most once per tick, far apart from each other
// Notes: Each step but the last runs a 32-cycle shift divider before the output moves; the last lands at once
module gain_ramp
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire gain_sched_pkg::word_t set1_in,
    input wire gain_sched_pkg::word_t set2_in,
    input wire logic to_set2_in,
    input wire logic follow_in,
    input wire logic load_in,
    input wire logic calc_in,
    input wire gain_sched_pkg::word_t step_in,
    input wire gain_sched_pkg::word_t span_in,
    output gain_sched_pkg::word_t value_out
);
    import gain_sched_pkg::*;

    ramp_state_t r;
    ramp_state_t n;
    word_t dst;
    word_t mag;
    logic [16:0] sh;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n = r;
        dst = to_set2_in ? set2_in : set1_in;
        mag = '0;
        sh = {r.rem, r.num[31]};
        if (follow_in) begin
            n.val = dst; // Settled: track set value live
            n.busy = 1'b0;
        end else if (load_in) begin
            n.src = r.val;
            n.busy = 1'b0;
        end else if (calc_in) begin
            if (step_in >= span_in) begin
                n.val = dst;
                n.busy = 1'b0;
            end else begin
                n.neg = dst < r.src;
                mag = n.neg ? r.src - dst : dst - r.src;
                n.num = 32'(mag) * 32'(step_in);
                n.rem = '0;
                n.quo = '0;
                n.bits = 6'h20;
                n.busy = 1'b1;
            end
        end else if (r.busy) begin
            // One restoring division bit per cycle
            n.num = {r.num[30:0], 1'b0};
            if (sh >= {1'b0, span_in}) begin
                n.rem = 16'(sh - {1'b0, span_in});
                n.quo = {r.quo[14:0], 1'b1};
            end else begin
                n.rem = sh[15:0];
                n.quo = {r.quo[14:0], 1'b0};
            end
            n.bits = r.bits - 6'h01;
            if (r.bits == 6'h01) begin
                n.busy = 1'b0;
                n.val = r.neg ? r.src - n.quo : r.src + n.quo;
            end
        end
        if (!nrst_in) begin
            n = '0;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        r <= n;
    end

    assign value_out = r.val;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_ramp_lands_exact: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (calc_in && !load_in && step_in >= span_in) |=> value_out == $past(dst))
        else $error("ramp did not land on the destination value");
endmodule

//--- gain_sched_defs.svh
// Purpose: Offsets, field positions, limits and timing of the gain scheduler
// Assumes: 16-bit register words at 5-bit word addresses
// Notes: Definitions only
`ifndef GAIN_SCHED_DEFS_SVH
`define GAIN_SCHED_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CFG 5'h00
`define REG_WAIT1 5'h01
`define REG_WAIT2 5'h02
`define REG_RAMP1 5'h03
`define REG_RAMP2 5'h04
`define REG_STATUS 5'h05
`define REG_GAIN_BASE 5'h08
`define GAIN_REGS 5'h0e
`define RAMPED_GAINS 5
// ----------------------------------------
// Config fields and codes
// ----------------------------------------
`define CFG_W 9
`define CFG_SEL_LSB 4
`define CFG_FORM_BIT 8
`define MODE_MANUAL 4'h0
`define MODE_AUTO1 4'h2
`define SEL_DONE_ON 4'h0
`define SEL_DONE_OFF 4'h1
`define SEL_NEAR_ON 4'h2
`define SEL_NEAR_OFF 4'h3
`define SEL_IDLE 4'h4
`define SEL_PULSE 4'h5
// ----------------------------------------
// Gain indices, limits and reset values
// ----------------------------------------
`define GI_SPD 3'h0
`define GI_INT 3'h1
`define GI_POS 3'h2
`define GI_TRQ 3'h3
`define GI_FRC 3'h4
`define GI_MFG 3'h5
`define GI_MFC 3'h6
`define LOOP_MIN 16'h000a
`define LOOP_MAX 16'h4e20
`define LOOP_RST 16'h0190
`define INT_MIN 16'h000f
`define INT_MAX 16'hc800
`define INT_RST 16'h07d0
`define TRQ_MIN 16'h0000
`define TRQ_MAX 16'hffff
`define TRQ_RST 16'h0064
`define FRC_MIN 16'h000a
`define FRC_MAX 16'h03e8
`define FRC_RST 16'h0064
`define MFG_RST 16'h01f4
`define MFC_MIN 16'h01f4
`define MFC_MAX 16'h07d0
`define MFC_RST 16'h03e8
// ----------------------------------------
// Timing
// ----------------------------------------
`define TICK_MS 1
`define CLK_KHZ 250000
`define TICK_W 18
`endif

//--- gain_sched_pkg.sv
// Purpose: Types shared by the gain scheduler and its ramp units
// Assumes: Constants come from the defs header
// Notes: Scheduler and ramp unit state each live in one packed struct per module
`include "gain_sched_defs.svh"
package gain_sched_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_WAIT = 2'b01,
        ST_RAMP = 2'b10
    } sched_st_t;
    typedef struct packed {
        logic [`GAIN_REGS-1:0][15:0] gains;
        word_t wait1;
        word_t wait2;
        word_t ramp1;
        word_t ramp2;
        logic [`CFG_W-1:0] cfg;
        word_t rd_data;
        logic [`TICK_W-1:0] tick_cnt;
        logic tick;
        logic load;
        logic calc;
        logic target;
        logic mf_sel;
        sched_st_t st;
        word_t cnt;
        word_t mf_gain;
        word_t mf_corr;
    } sched_state_t;
    typedef struct packed {
        word_t src;
        word_t val;
        logic [31:0] num;
        word_t rem;
        word_t quo;
        logic [5:0] bits;
        logic busy;
        logic neg;
    } ramp_state_t;
endpackage

//--- gain_scheduler.sv
// Purpose: Chooses and blends the two controller gain sets for the loops
// Assumes: Status inputs synchronous to the system clock
// Notes: Timing runs on a 1 ms tick; register bus is a plain strobe port
`include "gain_sched_defs.svh"
module gain_scheduler #(
    parameter int TICK_CYCLES = `TICK_MS * `CLK_KHZ
) (
    input wire logic CLK_SYS_IN,
    input wire logic NRST_IN,
    input wire logic [4:0] ADDR_IN,
    input wire gain_sched_pkg::word_t WR_DATA_IN,
    input wire logic WR_STB_IN,
    input wire logic RD_STB_IN,
    input wire logic POS_CTRL_IN,
    input wire logic POSITIONING_DONE_IN,
    input wire logic NEAR_IN,
    input wire logic REF_PULSE_IN,
    input wire logic FILTER_ZERO_IN,
    input wire logic GAIN_SEL_IN,
    input wire logic REF_PRESENT_IN,
    input wire logic MOTOR_STOPPED_IN,
    output gain_sched_pkg::word_t RD_DATA_OUT,
    output gain_sched_pkg::word_t SPEED_GAIN_OUT,
    output gain_sched_pkg::word_t INTEGRAL_TIME_OUT,
    output gain_sched_pkg::word_t POSITION_GAIN_OUT,
    output gain_sched_pkg::word_t TORQUE_FILTER_OUT,
    output gain_sched_pkg::word_t FRICTION_GAIN_OUT,
    output gain_sched_pkg::word_t MF_GAIN_OUT,
    output gain_sched_pkg::word_t MF_CORR_OUT,
    output logic ACTIVE_SET_OUT,
    output logic SPEED_FORM_OUT
);
    import gain_sched_pkg::*;

    localparam logic [`TICK_W-1:0] TICK_LAST = `TICK_W'(TICK_CYCLES - 1);

    sched_state_t r;
    sched_state_t n;
    logic [3:0] mode;
    logic [3:0] sel;
    logic auto_mode;
    logic timed;
    logic cond_a;
    logic desired;
    logic follow;
    word_t wait_t;
    word_t span_t;
    word_t ramp_val [`RAMPED_GAINS];

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    // Limits {min, max, reset} per gain kind
    function automatic logic [47:0] gain_lim(input logic [2:0] g);
        unique case (g)
            `GI_SPD, `GI_POS: gain_lim = {`LOOP_MIN, `LOOP_MAX, `LOOP_RST};
            `GI_INT: gain_lim = {`INT_MIN, `INT_MAX, `INT_RST};
            `GI_TRQ: gain_lim = {`TRQ_MIN, `TRQ_MAX, `TRQ_RST};
            `GI_FRC: gain_lim = {`FRC_MIN, `FRC_MAX, `FRC_RST};
            `GI_MFG: gain_lim = {`LOOP_MIN, `LOOP_MAX, `MFG_RST};
            default: gain_lim = {`MFC_MIN, `MFC_MAX, `MFC_RST};
        endcase
    endfunction

    // Saturate a written value into its legal range
    function automatic word_t clamp_gain(input logic [2:0] g, input word_t v);
        logic [47:0] lim;
        lim = gain_lim(g);
        if (v < lim[47:32]) begin
            clamp_gain = lim[47:32];
        end else if (v > lim[31:16]) begin
            clamp_gain = lim[31:16];
        end else begin
            clamp_gain = v;
        end
    endfunction

    // Address falls in the gain window
    function automatic logic is_gain(input logic [4:0] a);
        is_gain = (a >= `REG_GAIN_BASE) && (a < `REG_GAIN_BASE + `GAIN_REGS);
    endfunction

    // Gain register index of an address
    function automatic logic [3:0] gain_idx(input logic [4:0] a);
        gain_idx = 4'(a - `REG_GAIN_BASE);
    endfunction

    // Condition A per selector code
    function automatic logic cond_of(input logic [3:0] s);
        unique case (s)
            `SEL_DONE_ON: cond_of = POSITIONING_DONE_IN;
            `SEL_DONE_OFF: cond_of = !POSITIONING_DONE_IN;
            `SEL_NEAR_ON: cond_of = NEAR_IN;
            `SEL_NEAR_OFF: cond_of = !NEAR_IN;
            `SEL_IDLE: cond_of = FILTER_ZERO_IN && !REF_PULSE_IN;
            `SEL_PULSE: cond_of = REF_PULSE_IN;
            default: cond_of = 1'b0;
        endcase
    endfunction

    // ----------------------------------------
    // Switching decision
    // ----------------------------------------
    // Speed loop form bit is not consulted here
    always_comb begin
        mode = r.cfg[3:0];
        sel = r.cfg[`CFG_SEL_LSB+3:`CFG_SEL_LSB];
        auto_mode = (mode == `MODE_AUTO1);
        timed = auto_mode && POS_CTRL_IN;
        cond_a = cond_of(sel);
        if (timed) begin
            desired = cond_a;
        end else if (auto_mode) begin
            desired = sel[0];
        end else begin
            desired = GAIN_SEL_IN;
        end
        wait_t = r.target ? r.wait1 : r.wait2;
        span_t = r.target ? r.ramp1 : r.ramp2;
        follow = (r.st == ST_HOLD);
    end

    // ----------------------------------------
    // Next state: tick, registers, sequencer
    // ----------------------------------------
    always_comb begin
        n = r;
        n.tick = 1'b0;
        n.load = 1'b0;
        n.calc = 1'b0;
        n.rd_data = '0;
        // Millisecond tick divider
        if (r.tick_cnt >= TICK_LAST) begin
            n.tick_cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.tick_cnt = r.tick_cnt + `TICK_W'(1);
        end
        // Register writes
        if (WR_STB_IN) begin
            if (ADDR_IN == `REG_CFG) begin
                n.cfg = WR_DATA_IN[`CFG_W-1:0];
            end else if (ADDR_IN == `REG_WAIT1) begin
                n.wait1 = WR_DATA_IN;
            end else if (ADDR_IN == `REG_WAIT2) begin
                n.wait2 = WR_DATA_IN;
            end else if (ADDR_IN == `REG_RAMP1) begin
                n.ramp1 = WR_DATA_IN;
            end else if (ADDR_IN == `REG_RAMP2) begin
                n.ramp2 = WR_DATA_IN;
            end else if (is_gain(ADDR_IN)) begin
                n.gains[gain_idx(ADDR_IN)] =
                    clamp_gain(3'(gain_idx(ADDR_IN) >> 1), WR_DATA_IN);
            end
        end
        // Register reads, answered next cycle
        if (RD_STB_IN) begin
            if (ADDR_IN == `REG_CFG) begin
                n.rd_data = 16'(r.cfg);
            end else if (ADDR_IN == `REG_WAIT1) begin
                n.rd_data = r.wait1;
            end else if (ADDR_IN == `REG_WAIT2) begin
                n.rd_data = r.wait2;
            end else if (ADDR_IN == `REG_RAMP1) begin
                n.rd_data = r.ramp1;
            end else if (ADDR_IN == `REG_RAMP2) begin
                n.rd_data = r.ramp2;
            end else if (ADDR_IN == `REG_STATUS) begin
                n.rd_data = {11'h000, cond_a, POS_CTRL_IN, r.st, r.target};
            end else if (is_gain(ADDR_IN)) begin
                n.rd_data = r.gains[gain_idx(ADDR_IN)];
            end
        end
        // Gain set sequencer
        if (!timed) begin
            n.st = ST_HOLD;
            n.target = desired;
            n.cnt = '0;
        end else if (desired != r.target) begin
            // Reload source: freezes gains, drops any divide in flight
            n.target = desired;
            n.st = ST_WAIT;
            n.cnt = '0;
            n.load = 1'b1;
        end else begin
            unique case (r.st)
                ST_HOLD: begin
                    n.cnt = '0;
                end
                ST_WAIT: begin
                    if (r.tick) begin
                        if ({1'b0, r.cnt} + 17'h00001 >= {1'b0, wait_t}) begin
                            n.cnt = '0;
                            n.load = 1'b1;
                            n.st = (span_t == '0) ? ST_HOLD : ST_RAMP;
                        end else begin
                            n.cnt = r.cnt + 16'h0001;
                        end
                    end
                end
                ST_RAMP: begin
                    if (r.tick) begin
                        n.cnt = r.cnt + 16'h0001;
                        n.calc = 1'b1;
                        if ({1'b0, r.cnt} + 17'h00001 >= {1'b0, span_t}) begin
                            n.st = ST_HOLD;
                        end
                    end
                end
                default: begin
                    n.st = ST_HOLD;
                end
            endcase
        end
        // Model-follow set changes only when safe
        if (mode == `MODE_MANUAL && !REF_PRESENT_IN && MOTOR_STOPPED_IN) begin
            n.mf_sel = GAIN_SEL_IN;
        end
        n.mf_gain = r.gains[{`GI_MFG, r.mf_sel}];
        n.mf_corr = r.gains[{`GI_MFC, r.mf_sel}];
        // Synchronous reset to defaults
        if (!NRST_IN) begin
            n = '0;
            for (int i = 0; i < `GAIN_REGS; i++) begin
                n.gains[i] = 16'(gain_lim(3'(i >> 1)));
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_IN) begin
        r <= n;
    end

    // ----------------------------------------
    // Ramp units for the timed gains
    // ----------------------------------------
    for (genvar g = 0; g < `RAMPED_GAINS; g++) begin : g_ramp
        gain_ramp u_ramp (
            .clk_in(CLK_SYS_IN),
            .nrst_in(NRST_IN),
            .set1_in(r.gains[2*g]),
            .set2_in(r.gains[2*g+1]),
            .to_set2_in(r.target),
            .follow_in(follow),
            .load_in(r.load),
            .calc_in(r.calc),
            .step_in(r.cnt),
            .span_in(span_t),
            .value_out(ramp_val[g])
        );
    end

    // Outputs
    assign SPEED_GAIN_OUT = ramp_val[`GI_SPD];
    assign INTEGRAL_TIME_OUT = ramp_val[`GI_INT];
    assign POSITION_GAIN_OUT = ramp_val[`GI_POS];
    assign TORQUE_FILTER_OUT = ramp_val[`GI_TRQ];
    assign FRICTION_GAIN_OUT = ramp_val[`GI_FRC];
    assign MF_GAIN_OUT = r.mf_gain;
    assign MF_CORR_OUT = r.mf_corr;
    assign ACTIVE_SET_OUT = r.target;
    assign SPEED_FORM_OUT = r.cfg[`CFG_FORM_BIT];
    assign RD_DATA_OUT = r.rd_data;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!NRST_IN);

    chk_no_auto_outside: assert property (
        (auto_mode && !POS_CTRL_IN) |=> r.st == ST_HOLD)
        else $error("timed switching outside position control");
    chk_fixed_set_code: assert property (
        (auto_mode && !POS_CTRL_IN) |=> r.target == $past(sel[0]))
        else $error("wrong fixed set outside position control");
    chk_cond_a_starts: assert property (
        (timed && sel == `SEL_DONE_ON && POSITIONING_DONE_IN && !r.target)
        |=> r.target && r.st == ST_WAIT && r.cnt == '0)
        else $error("condition A did not start a move to set 2");
    chk_cond_clear_back: assert property (
        (timed && sel == `SEL_PULSE && !REF_PULSE_IN && r.target)
        |=> !r.target && r.st == ST_WAIT)
        else $error("condition clear did not start a move to set 1");
    chk_wait_holds_gain: assert property (
        (r.st == ST_WAIT ##1 r.st == ST_WAIT) |-> $stable(POSITION_GAIN_OUT))
        else $error("gain moved during the waiting time");
    chk_zero_wait_leaves: assert property (
        (timed && r.st == ST_WAIT && r.tick && wait_t == '0 && desired == r.target)
        |=> r.load && r.st != ST_WAIT)
        else $error("zero waiting time did not start the move");
    chk_ramp_ends: assert property (
        (r.st == ST_RAMP && r.tick && desired == r.target && r.cnt + 16'h0001 == span_t)
        |=> r.st == ST_HOLD ##[1:40] POSITION_GAIN_OUT == r.gains[{`GI_POS, r.target}])
        else $error("ramp did not finish on the final step");
    chk_manual_select: assert property (
        (mode == `MODE_MANUAL) |=> r.target == $past(GAIN_SEL_IN))
        else $error("manual select not followed");
    chk_mf_switch_safe: assert property (
        $changed(r.mf_sel) |-> $past(mode == `MODE_MANUAL && !REF_PRESENT_IN
        && MOTOR_STOPPED_IN))
        else $error("model-follow set changed while unsafe");
    chk_gain_clamped: assert property (
        (WR_STB_IN && ADDR_IN == `REG_GAIN_BASE + 5'h04 && WR_DATA_IN < `LOOP_MIN)
        |=> r.gains[4] == `LOOP_MIN)
        else $error("low write to loop gain not clamped");
    chk_reversal_restart: assert property (
        (timed && r.st == ST_RAMP && desired != r.target)
        |=> r.st == ST_WAIT && r.cnt == '0)
        else $error("reversal did not restart the wait");

    cov_ramp_seen: cover property (r.st == ST_WAIT ##[1:1000] r.st == ST_RAMP);
    cov_ramp_done: cover property (r.st == ST_RAMP ##1 r.st == ST_HOLD);
    cov_reversal: cover property (r.st == ST_RAMP ##1 r.st == ST_WAIT);
    cov_manual_set2: cover property (mode == `MODE_MANUAL && GAIN_SEL_IN ##1 r.target);
endmodule
